// ===== hdl/psw_defs.svh
// register offsets, field positions and reset values of the waveform core
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH

// register byte offsets
`define PSW_OFF_CTRL 12'h000
`define PSW_OFF_SET_A 12'h004
`define PSW_OFF_RESET_A 12'h008
`define PSW_OFF_SET_B 12'h00C
`define PSW_OFF_RESET_B 12'h010
`define PSW_OFF_OUT_CFG 12'h014
`define PSW_OFF_OUT_MTX 12'h018
`define PSW_OFF_STATUS 12'h01C

// control register fields
`define PSW_CTRL_RUN 0
`define PSW_CTRL_MODE 1
`define PSW_CTRL_FIFTY 3
`define PSW_CTRL_HOLD 4
`define PSW_CTRL_AUTO 5
`define PSW_CTRL_ENH 6
`define PSW_CTRL_LOC 7
`define PSW_CTRL_FEIE 9
`define PSW_CTRL_W 10

// reset_b_compare: divider sits above the 12-bit compare
`define PSW_FRAC_LSB 12
`define PSW_RB_W 16

// status register fields
`define PSW_ST_RUN 0
`define PSW_ST_FRAME 1
`define PSW_ST_STATE 5
`define PSW_ST_OUT_A 7
`define PSW_ST_OUT_B 8
`define PSW_ST_AUTO 9
`define PSW_ST_RBWR 10

// reset values
`define PSW_RST_CTRL 10'h000
`define PSW_RST_CMP 12'h000
`define PSW_RST_RB 16'h0000
`define PSW_RST_BYTE 8'h00

// next to last cycle of an enhanced frame, whose end raises the frame-end request
`define PSW_FRAME_LAST_IRQ 4'hE

`endif

// ===== hdl/psw_pkg.sv
// types shared by the waveform timing core
`default_nettype none
package psw_pkg;

   // running modes, encoding as held in the control register
   typedef enum logic [1:0] {
      PSW_FOUR = 2'b00,
      PSW_TWO = 2'b01,
      PSW_ONE = 2'b10,
      PSW_CENTER = 2'b11
   } psw_mode_e;

   // ramp states, gray along the four ramp path
   typedef enum logic [1:0] {
      PSW_RA0 = 2'b00,
      PSW_RA1 = 2'b01,
      PSW_RB0 = 2'b11,
      PSW_RB1 = 2'b10
   } psw_state_e;

endpackage : psw_pkg
`default_nettype wire

// ===== hdl/psw_waveform_timing.sv
// waveform timing core of the power stage unit with apb registers
// How it works
// - four ramp: on-time is reset compare, dead-time set compare plus two.
// - two ramp: on-time reset minus set, dead-time set plus one.
// - one ramp: single ramp, outputs overlap, set/reset thresholds on it.
// - center: up/down ramp, pulses centered, cycle twice reset-B plus two.
// - center mode ignores reset-A for waveforms; kept for conversion trigger.
// - fifty percent copies part B compares into part A.
// - stopped loads immediately; running loads whole set at cycle end; center mode loads at the top of its up ramp instead.
// - software may stop early; restart begins a fresh cycle.
// - auto-commit loads at cycle end after a reset-B write only.
// - auto-commit selection changes only at end of a cycle or while stopped.
// - hold blocks loading; after clearing, load at current cycle end.
// - hold and auto-commit cover config, matrix and all four compares.
// - auto-commit wins over hold when both are set.
// - enhanced mode groups 16 cycles; divider from reset-B bits 15:12.
// - location field picks which compares get the extra step.
// - lengthening per mode and location is zero, one or two clocks.
// - one/two ramp set locations alter width, not period.
// - d cycles of 16 lengthened in bit-reversed order, never cycle 15.
// - end of frame cycle 14 pulses a request when enabled.
// - new set loads at the top of the last ramp.
// - cycle is sub-cycle A then B, ends with end of B.
//
// The implementer's own choices: the APB slave port and the register offsets.
`default_nettype none
`include "psw_defs.svh"

module psw_waveform_timing
   import psw_pkg::*;
#(
   parameter int CMP_W = 12,
   parameter int FRAC_W = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // waveform outputs
   output logic out_part_a,
   output logic out_part_b,
   // events and values for neighbouring logic
   output logic cycle_end,
   output logic frame_end_irq,
   output logic generator_running,
   output logic [CMP_W-1:0] adc_trigger_compare,
   output logic [7:0] sync_output_config,
   output logic [7:0] output_matrix
);

   localparam int CNT_W = CMP_W + 1;
   localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // decode used by the error answer; read data decodes on its own
   function automatic logic is_mapped(input logic [11:0] a);
      if (a == `PSW_OFF_CTRL) is_mapped = 1'b1;
      else if (a == `PSW_OFF_SET_A) is_mapped = 1'b1;
      else if (a == `PSW_OFF_RESET_A) is_mapped = 1'b1;
      else if (a == `PSW_OFF_SET_B) is_mapped = 1'b1;
      else if (a == `PSW_OFF_RESET_B) is_mapped = 1'b1;
      else if (a == `PSW_OFF_OUT_CFG) is_mapped = 1'b1;
      else if (a == `PSW_OFF_OUT_MTX) is_mapped = 1'b1;
      else if (a == `PSW_OFF_STATUS) is_mapped = 1'b1;
      else is_mapped = 1'b0;
   endfunction : is_mapped

   // bit reversal gives the even spread 0,8,4,12,2,...
   function automatic logic [3:0] bitrev4(input logic [3:0] v);
      bitrev4 = {v[0], v[1], v[2], v[3]};
   endfunction : bitrev4

   // length minus one, a zero length still takes one clock
   function automatic logic [CNT_W-1:0] last_of(
      input logic [CNT_W-1:0] len);
      last_of = (len == '0) ? '0 : len - ONE_C;
   endfunction : last_of

   ////////////////////////////////////////////////////////////////////////
   // software visible buffers

   logic [`PSW_CTRL_W-1:0] ctrl;
   logic [CMP_W-1:0] buf_sa;
   logic [CMP_W-1:0] buf_ra;
   logic [CMP_W-1:0] buf_sb;
   logic [`PSW_RB_W-1:0] buf_rb;
   logic [7:0] buf_cfg;
   logic [7:0] buf_mtx;

   logic wr;
   logic run;
   psw_mode_e mode;
   logic fifty;
   logic hold;
   logic auto_sel;
   logic enh;
   logic [1:0] loc;
   logic feie;

   assign wr = psel & penable & pwrite;
   assign run = ctrl[`PSW_CTRL_RUN];
   assign mode = psw_mode_e'(ctrl[`PSW_CTRL_MODE +: 2]);
   assign fifty = ctrl[`PSW_CTRL_FIFTY];
   assign hold = ctrl[`PSW_CTRL_HOLD];
   assign auto_sel = ctrl[`PSW_CTRL_AUTO];
   assign enh = ctrl[`PSW_CTRL_ENH];
   assign loc = ctrl[`PSW_CTRL_LOC +: 2];
   assign feie = ctrl[`PSW_CTRL_FEIE];

   // zero wait state slave
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);

   // register writes; buffers never touch the running waveform directly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `PSW_RST_CTRL;
         buf_sa <= `PSW_RST_CMP;
         buf_ra <= `PSW_RST_CMP;
         buf_sb <= `PSW_RST_CMP;
         buf_rb <= `PSW_RST_RB;
         buf_cfg <= `PSW_RST_BYTE;
         buf_mtx <= `PSW_RST_BYTE;
      end else if (wr) begin
         if (paddr == `PSW_OFF_CTRL) begin
            ctrl <= pwdata[`PSW_CTRL_W-1:0];
         end else if (paddr == `PSW_OFF_SET_A) begin
            buf_sa <= pwdata[CMP_W-1:0];
         end else if (paddr == `PSW_OFF_RESET_A) begin
            buf_ra <= pwdata[CMP_W-1:0];
         end else if (paddr == `PSW_OFF_SET_B) begin
            buf_sb <= pwdata[CMP_W-1:0];
         end else if (paddr == `PSW_OFF_RESET_B) begin
            buf_rb <= pwdata[`PSW_RB_W-1:0];
         end else if (paddr == `PSW_OFF_OUT_CFG) begin
            buf_cfg <= pwdata[7:0];
         end else if (paddr == `PSW_OFF_OUT_MTX) begin
            buf_mtx <= pwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // working set and commit control

   logic [CMP_W-1:0] w_sa;
   logic [CMP_W-1:0] w_ra;
   logic [CMP_W-1:0] w_sb;
   logic [`PSW_RB_W-1:0] w_rb;
   logic auto_eff;
   logic rb_wr_seen;
   logic load_pt;
   logic cyc_end;
   logic do_commit;

   // auto-commit first, hold only matters without it
   assign do_commit = ~run
      | (load_pt & (auto_eff ? rb_wr_seen : ~hold));

   // whole set moves together so no cycle mixes old and new
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_sa <= `PSW_RST_CMP;
         w_ra <= `PSW_RST_CMP;
         w_sb <= `PSW_RST_CMP;
         w_rb <= `PSW_RST_RB;
         sync_output_config <= `PSW_RST_BYTE;
         output_matrix <= `PSW_RST_BYTE;
      end else if (do_commit) begin
         w_sa <= buf_sa;
         w_ra <= buf_ra;
         w_sb <= buf_sb;
         w_rb <= buf_rb;
         sync_output_config <= buf_cfg;
         output_matrix <= buf_mtx;
      end
   end

   // a reset-B write while running arms the auto-commit load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_wr_seen <= 1'b0;
      end else if (wr && paddr == `PSW_OFF_RESET_B && run) begin
         rb_wr_seen <= 1'b1;
      end else if (do_commit) begin
         rb_wr_seen <= 1'b0;
      end
   end

   // selection itself only switches at a cycle end or while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_eff <= 1'b0;
      end else if (!run || cyc_end) begin
         auto_eff <= auto_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // effective compares and enhanced modulation

   logic [3:0] frame_idx;
   logic [FRAC_W-1:0] frac;
   logic modul;
   logic [CMP_W-1:0] s_a;
   logic [CMP_W-1:0] r_a;
   logic [CNT_W-1:0] e_sa;
   logic [CNT_W-1:0] e_ra;
   logic [CNT_W-1:0] e_sb;
   logic [CNT_W-1:0] e_rb;
   logic add_sa;
   logic add_ra;
   logic add_sb;
   logic add_rb;

   assign frac = w_rb[`PSW_FRAC_LSB +: FRAC_W];
   assign modul = enh & (bitrev4(frame_idx) < frac);
   assign s_a = fifty ? w_sb : w_sa;
   assign r_a = fifty ? w_rb[CMP_W-1:0] : w_ra;

   // extra step per location; center lengthens both ramps instead
   always_comb begin
      add_sa = 1'b0;
      add_ra = 1'b0;
      add_sb = 1'b0;
      add_rb = 1'b0;
      if (modul && mode != PSW_CENTER) begin
         add_rb = ~loc[1];
         add_ra = (loc == 2'b01);
         add_sb = loc[1];
         add_sa = (loc == 2'b11);
      end
   end

   assign e_sa = {1'b0, s_a} + CNT_W'(add_sa);
   assign e_ra = {1'b0, r_a} + CNT_W'(add_ra);
   assign e_sb = {1'b0, w_sb} + CNT_W'(add_sb);
   assign e_rb = {1'b0, w_rb[CMP_W-1:0]} + CNT_W'(add_rb);

   ////////////////////////////////////////////////////////////////////////
   // ramp sequencer

   psw_state_e state;
   psw_state_e next_state;
   psw_state_e first_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] top;
   logic ramp_end;

   // terminal count of the ramp in progress
   always_comb begin
      top = e_rb;
      first_state = PSW_RB1;
      case (mode)
         PSW_FOUR: begin
            first_state = PSW_RA0;
            case (state)
               PSW_RA0: top = e_sa + ONE_C;
               PSW_RA1: top = last_of(e_ra);
               PSW_RB0: top = e_sb + ONE_C;
               default: top = last_of(e_rb);
            endcase
         end
         PSW_TWO: begin
            first_state = PSW_RA1;
            top = (state == PSW_RA1) ? e_ra : e_rb;
         end
         PSW_ONE: begin
            top = e_rb;
         end
         default: begin
            first_state = PSW_RB0;
            top = e_rb + CNT_W'(modul);
         end
      endcase
   end

   // center goes down on its second ramp and ends at zero
   assign ramp_end = (mode == PSW_CENTER && state == PSW_RB1)
      ? (cnt == '0) : (cnt == top);
   assign cyc_end = run & ramp_end & (state == PSW_RB1);
   assign load_pt = run & ramp_end
      & (state == ((mode == PSW_CENTER) ? PSW_RB0 : PSW_RB1));

   // successor ramp per mode
   always_comb begin
      next_state = first_state;
      case (mode)
         PSW_FOUR: begin
            case (state)
               PSW_RA0: next_state = PSW_RA1;
               PSW_RA1: next_state = PSW_RB0;
               PSW_RB0: next_state = PSW_RB1;
               default: next_state = PSW_RA0;
            endcase
         end
         PSW_TWO: begin
            next_state = (state == PSW_RA1) ? PSW_RB1 : PSW_RA1;
         end
         PSW_ONE: begin
            next_state = PSW_RB1;
         end
         default: begin
            next_state = (state == PSW_RB0) ? PSW_RB1 : PSW_RB0;
         end
      endcase
   end

   // stopped: parked at the first ramp so a restart is a fresh cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PSW_RA0;
         cnt <= '0;
      end else if (!run) begin
         state <= first_state;
         cnt <= '0;
      end else if (ramp_end) begin
         state <= next_state;
         if (mode == PSW_CENTER && state == PSW_RB0) begin
            cnt <= top;
         end else begin
            cnt <= '0;
         end
      end else if (mode == PSW_CENTER && state == PSW_RB1) begin
         cnt <= cnt - ONE_C;
      end else begin
         cnt <= cnt + ONE_C;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output levels

   logic lvl_a;
   logic lvl_b;

   // compare of ramp position against effective thresholds
   always_comb begin
      lvl_a = 1'b0;
      lvl_b = 1'b0;
      case (mode)
         PSW_FOUR: begin
            lvl_a = (state == PSW_RA1);
            lvl_b = (state == PSW_RB1);
         end
         PSW_TWO: begin
            lvl_a = (state == PSW_RA1) && (cnt > e_sa);
            lvl_b = (state == PSW_RB1) && (cnt > e_sb);
         end
         PSW_ONE: begin
            lvl_a = (cnt > e_sa) && (cnt <= e_ra);
            lvl_b = (cnt > e_sb) && (cnt <= e_rb);
         end
         default: begin
            // reset-A plays no part here
            lvl_a = (cnt < e_sa);
            lvl_b = (cnt >= e_sb);
         end
      endcase
   end

   // outputs registered, low while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_part_a <= 1'b0;
         out_part_b <= 1'b0;
      end else begin
         out_part_a <= run & lvl_a;
         out_part_b <= run & lvl_b;
      end
   end

   // conversion trigger keeps reset-A even in center mode
   assign adc_trigger_compare = r_a;
   assign generator_running = run;

   ////////////////////////////////////////////////////////////////////////
   // frame position and events

   // restarts from zero on every start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_idx <= '0;
      end else if (!run) begin
         frame_idx <= '0;
      end else if (cyc_end) begin
         frame_idx <= frame_idx + 4'h1;
      end
   end

   // one-cycle pulses for the surrounding logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_end <= 1'b0;
         frame_end_irq <= 1'b0;
      end else begin
         cycle_end <= cyc_end;
         frame_end_irq <= cyc_end & enh & feie
            & (frame_idx == `PSW_FRAME_LAST_IRQ);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= '0;
         if (paddr == `PSW_OFF_CTRL) begin
            prdata[`PSW_CTRL_W-1:0] <= ctrl;
         end else if (paddr == `PSW_OFF_SET_A) begin
            prdata[CMP_W-1:0] <= buf_sa;
         end else if (paddr == `PSW_OFF_RESET_A) begin
            prdata[CMP_W-1:0] <= buf_ra;
         end else if (paddr == `PSW_OFF_SET_B) begin
            prdata[CMP_W-1:0] <= buf_sb;
         end else if (paddr == `PSW_OFF_RESET_B) begin
            prdata[`PSW_RB_W-1:0] <= buf_rb;
         end else if (paddr == `PSW_OFF_OUT_CFG) begin
            prdata[7:0] <= buf_cfg;
         end else if (paddr == `PSW_OFF_OUT_MTX) begin
            prdata[7:0] <= buf_mtx;
         end else if (paddr == `PSW_OFF_STATUS) begin
            prdata[`PSW_ST_RUN] <= run;
            prdata[`PSW_ST_FRAME +: 4] <= frame_idx;
            prdata[`PSW_ST_STATE +: 2] <= state;
            prdata[`PSW_ST_OUT_A] <= out_part_a;
            prdata[`PSW_ST_OUT_B] <= out_part_b;
            prdata[`PSW_ST_AUTO] <= auto_eff;
            prdata[`PSW_ST_RBWR] <= rb_wr_seen;
         end
      end
   end

endmodule : psw_waveform_timing
`default_nettype wire

// ===== dv/psw_switch_model.sv
// switch stage model: measures each output's on-time in clocks
`default_nettype none

module psw_switch_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // gate drive from the core
   input wire logic out_part_a,
   input wire logic out_part_b,
   // width of the last finished pulse
   output logic [15:0] on_a,
   output logic [15:0] on_b
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] run_a;
   logic [15:0] run_b;

   // a pulse is reported only once the switch has turned off again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_a <= 16'h0000;
         on_a <= 16'h0000;
      end else if (out_part_a) begin
         run_a <= run_a + 16'h0001;
      end else if (run_a != 16'h0000) begin
         on_a <= run_a;
         run_a <= 16'h0000;
      end
   end

   // same for the low side switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_b <= 16'h0000;
         on_b <= 16'h0000;
      end else if (out_part_b) begin
         run_b <= run_b + 16'h0001;
      end else if (run_b != 16'h0000) begin
         on_b <= run_b;
         run_b <= 16'h0000;
      end
   end
endmodule : psw_switch_model
`default_nettype wire

// ===== dv/psw_monitor.sv
// port-level assertions of the waveform timing core
`default_nettype none
`include "psw_defs.svh"

module psw_monitor #(
   parameter int CMP_W = 12,
   parameter int FRAC_W = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // waveform and events
   input wire logic out_part_a,
   input wire logic out_part_b,
   input wire logic cycle_end,
   input wire logic frame_end_irq,
   input wire logic generator_running,
   input wire logic [CMP_W-1:0] adc_trigger_compare,
   input wire logic [7:0] sync_output_config,
   input wire logic [7:0] output_matrix
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic wr;
   logic fifty_sh;
   logic armed;
   logic [4:0] ends;
   logic [CMP_W-1:0] ra_sh;
   logic [CMP_W-1:0] rb_sh;
   logic [7:0] cfg_sh;
   logic [7:0] mtx_sh;

   ///////////////////////////////////////////////////////////////////////
   // accepted write; pready included so a wait state cannot fool us
   assign wr = psel && penable && pwrite && pready;

   // shadows of software writes, the values the working set must reach
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifty_sh <= 1'b0;
         ra_sh <= '0;
         rb_sh <= '0;
         cfg_sh <= 8'h00;
         mtx_sh <= 8'h00;
      end else if (wr) begin
         case (paddr)
            `PSW_OFF_CTRL: fifty_sh <= pwdata[`PSW_CTRL_FIFTY];
            `PSW_OFF_RESET_A: ra_sh <= pwdata[CMP_W-1:0];
            `PSW_OFF_RESET_B: rb_sh <= pwdata[CMP_W-1:0];
            `PSW_OFF_OUT_CFG: cfg_sh <= pwdata[7:0];
            `PSW_OFF_OUT_MTX: mtx_sh <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // cycle ends since the last frame request; a control write disarms
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ends <= 5'd0;
         armed <= 1'b0;
      end else begin
         ends <= frame_end_irq ? 5'd0 : ends + 5'(cycle_end);
         armed <= (wr && paddr == `PSW_OFF_CTRL) ? 1'b0
            : armed | frame_end_irq;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   sequence s_stopped;
      (!generator_running && !wr) [*4];
   endsequence

   sequence s_ctrl_wr;
      wr && paddr == `PSW_OFF_CTRL;
   endsequence

   AST_CYCLE_PULSE:
   assert property (cycle_end |=> !cycle_end)
      else $error("cycle end longer than one clock");
   AST_STOP_QUIET:
   assert property (s_stopped |-> !out_part_a && !out_part_b && !cycle_end)
      else $error("outputs active while stopped");
   AST_STOP_LOAD:
   assert property (s_stopped |->
      sync_output_config == cfg_sh && output_matrix == mtx_sh)
      else $error("stopped core did not load at once");
   AST_ADC_STOPPED:
   assert property (s_stopped |->
      adc_trigger_compare == (fifty_sh ? rb_sh : ra_sh))
      else $error("trigger compare wrong");
   AST_RUN_FROZEN:
   assert property (generator_running && $past(generator_running) &&
      $changed(output_matrix) |-> output_matrix == mtx_sh)
      else $error("matrix changed to a value never written");
   AST_RUN_FLAG:
   assert property (s_ctrl_wr |=> generator_running == $past(pwdata[0]))
      else $error("run flag does not follow control");
   AST_IRQ_WITH_END:
   assert property (frame_end_irq |-> cycle_end)
      else $error("frame request off a cycle end");
   AST_IRQ_PULSE:
   assert property (frame_end_irq |=> !frame_end_irq [*8])
      else $error("frame request too long");
   AST_FRAME_SPAN:
   assert property (frame_end_irq && armed |-> ends == 5'd15)
      else $error("frame is not sixteen cycles");
endmodule : psw_monitor
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench of the waveform timing core
`default_nettype none
`include "psw_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
$display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module tb
   import psw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RUN = 32'h0000_0001;
   localparam logic [31:0] FIFTY = 32'h0000_0008;
   localparam logic [31:0] HOLD = 32'h0000_0010;
   localparam logic [31:0] AUTO = 32'h0000_0020;
   localparam logic [31:0] ENH = 32'h0000_0240; // enhanced plus frame irq
   // mode (4: two ramp fifty), sa, ra, sb, rb, period, on a, on b
   int tbl [5][8] = '{'{0, 1, 5, 2, 7, 19, 5, 7}, '{1, 2, 6, 1, 4, 12, 4, 3},
      '{2, 1, 4, 3, 8, 9, 3, 5}, '{3, 3, 2, 5, 9, 20, 6, 10},
      '{4, 0, 0, 1, 4, 10, 3, 3}};
   // row, location, extra clocks of a lengthened cycle
   int enh [4][3] = '{'{0, 0, 1}, '{0, 1, 2}, '{1, 2, 0}, '{3, 0, 2}};
   int bad_count = 0;
   int cmp_count = 0;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rdata;
   logic rerr;
   logic pready;
   logic pslverr;
   logic out_part_a;
   logic out_part_b;
   logic cycle_end;
   logic frame_end_irq;
   logic generator_running;
   logic [11:0] adc_trigger_compare;
   logic [7:0] sync_output_config;
   logic [7:0] output_matrix;
   logic [15:0] on_a;
   logic [15:0] on_b;

   always #2 pclk = ~pclk;

   psw_waveform_timing DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .out_part_a(out_part_a), .out_part_b(out_part_b),
      .cycle_end(cycle_end), .frame_end_irq(frame_end_irq),
      .generator_running(generator_running),
      .adc_trigger_compare(adc_trigger_compare),
      .sync_output_config(sync_output_config),
      .output_matrix(output_matrix));

   psw_switch_model u_sw (.pclk(pclk), .presetn(presetn),
      .out_part_a(out_part_a), .out_part_b(out_part_b),
      .on_a(on_a), .on_b(on_b));

   ////////////////////////////////////////////////////////////////////////
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // clocks up to the next cycle end, sampled away from the edge
   task automatic wait_end(output int n);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (cycle_end !== 1'b1 && n < 5000);
   endtask : wait_end

   function automatic int rev(input int i);
      return {28'h0, i[0], i[1], i[2], i[3]};
   endfunction : rev

   // stop, load one table row, restart
   task automatic load(input int i, input logic [31:0] f,
      input logic [1:0] loc, input logic [3:0] d);
      logic [31:0] c;
      c = (tbl[i][0] == 4) ? (f | FIFTY | 32'h0000_0002) :
         (f | (32'(tbl[i][0]) << `PSW_CTRL_MODE));
      c = c | (32'(loc) << `PSW_CTRL_LOC);
      apb(1'b1, `PSW_OFF_CTRL, c & ~RUN);
      apb(1'b1, `PSW_OFF_SET_A, 32'(tbl[i][1]));
      apb(1'b1, `PSW_OFF_RESET_A, 32'(tbl[i][2]));
      apb(1'b1, `PSW_OFF_SET_B, 32'(tbl[i][3]));
      apb(1'b1, `PSW_OFF_RESET_B, {16'h0000, d, 12'(tbl[i][4])});
      apb(1'b1, `PSW_OFF_CTRL, c);
   endtask : load

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      apb(1'b0, `PSW_OFF_STATUS, 32'h0000_0000);
      `CHK(rdata, 32'h0000_0000)
      apb(1'b1, `PSW_OFF_SET_A, 32'hffff_fabc);
      apb(1'b0, `PSW_OFF_SET_A, 32'h0000_0000);
      `CHK(rdata, 32'h0000_0abc)
      apb(1'b1, `PSW_OFF_OUT_CFG, 32'h0000_003c);
      repeat (3) @(negedge pclk);
      `CHK(sync_output_config, 8'h3c)
      apb(1'b0, 12'h020, 32'h0000_0000);
      `CHK({rerr, rdata}, 33'h1_0000_0000)
   endtask : t_regs

   task automatic t_modes;
      int n;
      for (int i = 0; i < 5; i++) begin
         load(i, RUN, 2'b00, 4'h0);
         repeat (3) wait_end(n);
         `CHK(n, tbl[i][5])
         `CHK(on_a, 16'(tbl[i][6]))
         `CHK(on_b, 16'(tbl[i][7]))
         `CHK(adc_trigger_compare, 12'(tbl[i][i == 4 ? 4 : 2]))
      end
   endtask : t_modes

   task automatic t_lock;
      int n;
      load(0, RUN | HOLD, 2'b00, 4'h0);
      apb(1'b1, `PSW_OFF_OUT_MTX, 32'h0000_005a);
      apb(1'b1, `PSW_OFF_RESET_B, 32'h0000_0009);
      repeat (3) wait_end(n);
      `CHK({n, output_matrix}, {32'd19, 8'h00})
      apb(1'b1, `PSW_OFF_CTRL, RUN);
      repeat (3) wait_end(n);
      `CHK({n, output_matrix}, {32'd21, 8'h5a})
      apb(1'b1, `PSW_OFF_CTRL, RUN | HOLD | AUTO);
      repeat (2) wait_end(n);
      apb(1'b1, `PSW_OFF_OUT_MTX, 32'h0000_00a5);
      repeat (3) wait_end(n);
      `CHK(output_matrix, 8'h5a)
      apb(1'b1, `PSW_OFF_RESET_B, 32'h0000_0007);
      repeat (2) wait_end(n);
      `CHK({n, output_matrix}, {32'd19, 8'ha5})
   endtask : t_lock

   task automatic t_enh;
      int n;
      int k;
      int idx;
      for (int r = 0; r < 4; r++) begin
         load(enh[r][0], RUN | ENH, 2'(enh[r][1]), 4'h3);
         k = 0;
         do begin
            wait_end(n);
            k++;
         end while (frame_end_irq !== 1'b1 && k < 40);
         `CHK(k, 15)
         for (int c = 0; c < 16; c++) begin
            idx = (c + 15) % 16;
            wait_end(n);
            `CHK(n, tbl[enh[r][0]][5] + (rev(idx) < 3 ? enh[r][2] : 0))
            `CHK(frame_end_irq, idx == 14)
         end
      end
   endtask : t_enh

   task automatic test_done;
      $display("mismatches %0d of %0d compares", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   // main sequence after a four clock reset
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_modes;
      t_lock;
      t_enh;
      test_done;
   end

   // watchdog, about seventeen times the expected run
   initial begin
      #200000;
      bad_count++;
      test_done;
   end
endmodule : tb

bind psw_waveform_timing psw_monitor #(.CMP_W(CMP_W), .FRAC_W(FRAC_W)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .out_part_a(out_part_a), .out_part_b(out_part_b), .cycle_end(cycle_end),
   .frame_end_irq(frame_end_irq), .generator_running(generator_running),
   .adc_trigger_compare(adc_trigger_compare),
   .sync_output_config(sync_output_config), .output_matrix(output_matrix));
`default_nettype wire
